// ===== design/uimc_pkg.sv
package uimc_pkg;
  localparam int WB_AW = 5;
  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_IER = 3'h1;
  localparam logic [2:0] IDX_ISID = 3'h2;
  localparam logic [2:0] IDX_LFC = 3'h3;
  localparam logic [2:0] IDX_MLC = 3'h4;
  // line_format_control fields
  localparam int LFC_STOP = 2;
  localparam int LFC_PAR_EN = 3;
  localparam int LFC_PAR_EVEN = 4;
  localparam int LFC_STICK = 5;
  localparam int LFC_BREAK = 6;
  localparam int LFC_DIV_SEL = 7;
  // modem_line_control fields
  localparam int MLC_TERM_RDY = 0;
  localparam int MLC_REQ_SEND = 1;
  localparam int MLC_SPARE = 2;
  localparam int MLC_IRQ_GATE = 3;
  localparam int QSC_FIFO_EN = 0;
  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [4:0] MLC_RESET = 5'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  // interrupt identification codes, bits 3..0
  localparam logic [3:0] ISID_NONE = 4'h1;
  localparam logic [3:0] ISID_RLS = 4'h6;
  localparam logic [3:0] ISID_RDA = 4'h4;
  localparam logic [3:0] ISID_TMO = 4'hC;
  localparam logic [3:0] ISID_THRE = 4'h2;
  localparam logic [3:0] ISID_MSR = 4'h0;
  // serial timing in ticks of the 16x baud strobe
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICKS_STOP15 = 6'h18;
  localparam logic [5:0] TICKS_STOP2 = 6'h20;

  typedef enum logic [4:0] {
    SER_IDLE = 5'h01,
    SER_START = 5'h02,
    SER_DATA = 5'h04,
    SER_PAR = 5'h08,
    SER_STOP = 5'h10
  } uimc_ser_t;

  function automatic logic [7:0] uimc_len_mask(input logic [1:0] wl);
    uimc_len_mask = 8'hFF >> (2'h3 - wl);
  endfunction

  function automatic logic uimc_parity(input logic [7:0] d,
                                       input logic even,
                                       input logic stick);
    if (stick) begin
      uimc_parity = ~even;
    end else begin
      uimc_parity = even ? ^d : ~^d;
    end
  endfunction
endpackage

// ===== design/uimc_tx_if.sv
`timescale 1ns/1ps
interface uimc_tx_if;
  logic load;
  logic [7:0] data;
  logic [1:0] word_len;
  logic stop2;
  logic par_en;
  logic par_even;
  logic par_stick;
  logic brk;
  logic tick;
  logic busy;
  modport ctl (output load, data, word_len, stop2, par_en, par_even,
               par_stick, brk, tick, input busy);
  modport eng (input load, data, word_len, stop2, par_en, par_even,
               par_stick, brk, tick, output busy);
endinterface

// ===== design/uimc_tx.sv
`timescale 1ns/1ps
module uimc_tx (
  input wire logic clock,
  input wire logic rst_n,
  uimc_tx_if.eng tif,
  output logic txd
);
  import uimc_pkg::*;

  uimc_ser_t st_q;
  logic [5:0] cnt_q;
  logic [2:0] idx_q;
  logic [7:0] sh_q;
  logic par_q;
  logic [5:0] stop_last;
  logic [2:0] last_idx;
  logic line_bit;
  logic bit_end;

  assign tif.busy = (st_q != SER_IDLE);
  assign last_idx = 3'(3'h4 + {1'b0, tif.word_len});
  assign bit_end = tif.tick && (cnt_q == 6'(TICKS_BIT - 6'h01));

  always_comb begin
    stop_last = 6'(TICKS_BIT - 6'h01);
    if (tif.stop2 && tif.word_len == 2'h0) begin
      stop_last = 6'(TICKS_STOP15 - 6'h01);
    end else if (tif.stop2) begin
      stop_last = 6'(TICKS_STOP2 - 6'h01);
    end
  end

  always_comb begin
    case (st_q)
      SER_START: line_bit = 1'b0;
      SER_DATA: line_bit = sh_q[0];
      SER_PAR: line_bit = par_q;
      default: line_bit = 1'b1;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SER_IDLE;
      cnt_q <= 6'h00;
      idx_q <= 3'h0;
      sh_q <= 8'h00;
      par_q <= 1'b0;
    end else begin
      if (st_q != SER_IDLE && tif.tick) begin
        cnt_q <= 6'(cnt_q + 6'h01);
      end
      case (st_q)
        SER_IDLE: begin
          if (tif.load) begin
            sh_q <= tif.data & uimc_len_mask(tif.word_len);
            par_q <= uimc_parity(tif.data & uimc_len_mask(tif.word_len),
                                 tif.par_even, tif.par_stick);
            idx_q <= 3'h0;
            cnt_q <= 6'h00;
            st_q <= SER_START;
          end
        end
        SER_START: begin
          if (bit_end) begin
            cnt_q <= 6'h00;
            st_q <= SER_DATA;
          end
        end
        SER_DATA: begin
          if (bit_end) begin
            cnt_q <= 6'h00;
            sh_q <= sh_q >> 1;
            idx_q <= 3'(idx_q + 3'h1);
            if (idx_q == last_idx) begin
              st_q <= tif.par_en ? SER_PAR : SER_STOP;
            end
          end
        end
        SER_PAR: begin
          if (bit_end) begin
            cnt_q <= 6'h00;
            st_q <= SER_STOP;
          end
        end
        SER_STOP: begin
          if (tif.tick && cnt_q == stop_last) begin
            st_q <= SER_IDLE;
          end
        end
        default: st_q <= SER_IDLE;
      endcase
    end
  end

  // break overrides whatever the shifter is doing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txd <= 1'b1;
    end else begin
      txd <= tif.brk ? 1'b0 : line_bit;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_break_forces_low: assert property (tif.brk |=> !txd)
    else $error("break set but serial output not low");
  a_parity_slot: assert property (
    st_q == SER_PAR && !tif.brk |=> txd == $past(par_q))
    else $error("parity bit not driven in its slot");
  c_parity_frame: cover property (st_q == SER_PAR ##1 st_q == SER_STOP);
endmodule

// ===== design/uimc_top.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - identification bits 4 and 5 always read zero
// - identification bits 6 and 7 read one while fifo mode is on
// - codes: none 0001, line status 0110, data 0100, timeout 1100, tx 0010
// - modem status is lowest priority, code 0000, cleared by its own read
// - tx empty clears on identification read while reported or tx write
// - format bits 1..0 choose five to eight data bits
// - bit 2 gives one stop bit, or 1.5 for five bits, else two
// - receiver checks only the first stop bit
// - bit 3 adds a parity bit after data, before stop
// - bit 4 chooses odd at zero or even at one over data plus parity
// - bits 3 and 5 fix parity: zero when bit 4 set, else one
// - bit 6 holds serial output low until cleared
// - bit 7 steers offsets 0 and 1 to the divisor latches
// - modem bit 0 drives terminal ready pin low when set
// - modem bit 1 drives request to send pin the same way
// - modem bit 2 is a stored spare bit with no pin
// - modem bit 3 enables the interrupt pin, else it floats
// - identification bit 0 is zero while anything is pending, except a timeout outside fifo mode
// - bit 3 marks timeout in fifo mode, zero otherwise
// - fifo enable bit selects fifo mode for both directions
module uimc_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [uimc_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic baud_tick,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic line_status_pend,
  input wire logic rx_avail_pend,
  input wire logic char_timeout_pend,
  input wire logic modem_status_pend,
  output logic terminal_ready_n,
  output logic request_send_n,
  output logic irq_out,
  output logic irq_oe_n,
  output logic fifo_enable,
  output logic [15:0] divisor,
  output logic [3:0] int_enable,
  output logic [7:0] rx_char,
  output logic rx_char_valid,
  output logic rx_parity_err,
  output logic rx_frame_err
);
  import uimc_pkg::*;

  logic [7:0] line_format_control_q;
  logic [4:0] modem_line_control_q;
  logic [7:0] thr_q;
  logic thr_full_q;
  logic thre_pend_q;
  logic acc;
  logic aligned;
  logic wr;
  logic rd;
  logic [2:0] idx;
  logic divisor_select_bit;
  logic thr_wr;
  logic ier_wr;
  logic dll_wr;
  logic dlm_wr;
  logic qsc_wr;
  logic lfc_wr;
  logic mlc_wr;
  logic isid_read;
  logic tx_load;
  logic [3:0] isid_code;
  logic [7:0] isid_val;
  logic [7:0] rd_val;
  uimc_ser_t rx_st_q;
  logic [5:0] rx_cnt_q;
  logic [2:0] rx_idx_q;
  logic [7:0] rx_sh_q;
  logic rx_par_q;
  logic [2:0] rx_last_idx;
  logic [7:0] rx_aligned;
  logic rx_bit_end;

  uimc_tx_if tif();

  // single-cycle slave: ack one edge after the strobe, never two in a row
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign aligned = (wb_adr_i[1:0] == 2'b00);
  assign idx = wb_adr_i[4:2];
  assign wr = acc & wb_we_i & wb_sel_i[0] & aligned;
  assign rd = acc & ~wb_we_i & aligned;
  assign divisor_select_bit = line_format_control_q[LFC_DIV_SEL];
  assign isid_read = rd && idx == IDX_ISID;

  always_comb begin
    thr_wr = 1'b0;
    ier_wr = 1'b0;
    dll_wr = 1'b0;
    dlm_wr = 1'b0;
    qsc_wr = 1'b0;
    lfc_wr = 1'b0;
    mlc_wr = 1'b0;
    if (!wr) begin
      thr_wr = 1'b0;
    end else if (idx == IDX_DATA && !divisor_select_bit) begin
      thr_wr = 1'b1;
    end else if (idx == IDX_DATA) begin
      dll_wr = 1'b1;
    end else if (idx == IDX_IER && !divisor_select_bit) begin
      ier_wr = 1'b1;
    end else if (idx == IDX_IER) begin
      dlm_wr = 1'b1;
    end else if (idx == IDX_ISID) begin
      qsc_wr = 1'b1;
    end else if (idx == IDX_LFC) begin
      lfc_wr = 1'b1;
    end else if (idx == IDX_MLC) begin
      mlc_wr = 1'b1;
    end
  end

  // priority encoder; the code is sampled into the read data at the
  // acking edge, so a new event cannot tear an access in progress
  always_comb begin
    if (line_status_pend) begin
      isid_code = ISID_RLS;
    end else if (rx_avail_pend) begin
      isid_code = ISID_RDA;
    end else if (fifo_enable && char_timeout_pend) begin
      isid_code = ISID_TMO;
    end else if (thre_pend_q) begin
      isid_code = ISID_THRE;
    end else if (modem_status_pend) begin
      isid_code = ISID_MSR;
    end else begin
      isid_code = ISID_NONE;
    end
    isid_val = {{2{fifo_enable}}, 2'b00, isid_code};
  end

  always_comb begin
    rd_val = 8'h00;
    if (!aligned) begin
      rd_val = 8'h00;
    end else if (idx == IDX_DATA && !divisor_select_bit) begin
      rd_val = rx_char;
    end else if (idx == IDX_DATA) begin
      rd_val = divisor[7:0];
    end else if (idx == IDX_IER && !divisor_select_bit) begin
      rd_val = {4'h0, int_enable};
    end else if (idx == IDX_IER) begin
      rd_val = divisor[15:8];
    end else if (idx == IDX_ISID) begin
      rd_val = isid_val;
    end else if (idx == IDX_LFC) begin
      rd_val = line_format_control_q;
    end else if (idx == IDX_MLC) begin
      rd_val = {3'h0, modem_line_control_q};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= (acc && !wb_we_i) ? {24'h000000, rd_val} : 32'h00000000;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_format_control_q <= LFC_RESET;
      divisor <= DIV_RESET;
      int_enable <= 4'h0;
      fifo_enable <= 1'b0;
    end else begin
      if (lfc_wr) begin
        line_format_control_q <= wb_dat_i[7:0];
      end
      if (dll_wr) begin
        divisor[7:0] <= wb_dat_i[7:0];
      end
      if (dlm_wr) begin
        divisor[15:8] <= wb_dat_i[7:0];
      end
      if (ier_wr) begin
        int_enable <= wb_dat_i[3:0];
      end
      if (qsc_wr) begin
        fifo_enable <= wb_dat_i[QSC_FIFO_EN];
      end
    end
  end

  // pins follow the bits inverted; loopback lives outside this block
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      modem_line_control_q <= MLC_RESET;
      terminal_ready_n <= 1'b1;
      request_send_n <= 1'b1;
    end else if (mlc_wr) begin
      modem_line_control_q <= wb_dat_i[4:0];
      terminal_ready_n <= ~wb_dat_i[MLC_TERM_RDY];
      request_send_n <= ~wb_dat_i[MLC_REQ_SEND];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
      irq_oe_n <= 1'b1;
    end else begin
      irq_out <= ~isid_code[0];
      irq_oe_n <= ~modem_line_control_q[MLC_IRQ_GATE];
    end
  end

  // one holding byte in front of the shifter
  assign tx_load = thr_full_q & ~tif.busy;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      thr_q <= 8'h00;
      thr_full_q <= 1'b0;
    end else if (thr_wr) begin
      thr_q <= wb_dat_i[7:0];
      thr_full_q <= 1'b1;
    end else if (tx_load) begin
      thr_full_q <= 1'b0;
    end
  end

  // set on hand-off to the shifter wins over either clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      thre_pend_q <= 1'b0;
    end else if (tx_load) begin
      thre_pend_q <= 1'b1;
    end else if (thr_wr || (isid_read && isid_code == ISID_THRE)) begin
      thre_pend_q <= 1'b0;
    end
  end

  assign tif.load = tx_load;
  assign tif.data = thr_q;
  assign tif.word_len = line_format_control_q[1:0];
  assign tif.stop2 = line_format_control_q[LFC_STOP];
  assign tif.par_en = line_format_control_q[LFC_PAR_EN];
  assign tif.par_even = line_format_control_q[LFC_PAR_EVEN];
  assign tif.par_stick = line_format_control_q[LFC_STICK];
  assign tif.brk = line_format_control_q[LFC_BREAK];
  assign tif.tick = baud_tick;

  uimc_tx u_tx (
    .clock(clock),
    .rst_n(rst_n),
    .tif(tif),
    .txd(serial_out)
  );

  // receiver: start bit qualified at mid-bit, later bits sampled mid-bit
  assign rx_last_idx = 3'(3'h4 + {1'b0, line_format_control_q[1:0]});
  assign rx_aligned = rx_sh_q >> (2'h3 - line_format_control_q[1:0]);
  assign rx_bit_end = baud_tick && rx_cnt_q == 6'(TICKS_BIT - 6'h01);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= SER_IDLE;
      rx_cnt_q <= 6'h00;
      rx_idx_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_char <= 8'h00;
      rx_char_valid <= 1'b0;
      rx_parity_err <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_char_valid <= 1'b0;
      if (rx_st_q != SER_IDLE && baud_tick) begin
        rx_cnt_q <= 6'(rx_cnt_q + 6'h01);
      end
      case (rx_st_q)
        SER_IDLE: begin
          if (!serial_in) begin
            rx_cnt_q <= 6'h00;
            rx_sh_q <= 8'h00;
            rx_st_q <= SER_START;
          end
        end
        SER_START: begin
          if (baud_tick && rx_cnt_q == 6'(TICKS_HALF - 6'h01)) begin
            rx_cnt_q <= 6'h00;
            rx_idx_q <= 3'h0;
            rx_st_q <= serial_in ? SER_IDLE : SER_DATA;
          end
        end
        SER_DATA: begin
          if (rx_bit_end) begin
            rx_cnt_q <= 6'h00;
            rx_sh_q <= {serial_in, rx_sh_q[7:1]};
            rx_idx_q <= 3'(rx_idx_q + 3'h1);
            if (rx_idx_q == rx_last_idx) begin
              rx_st_q <= line_format_control_q[LFC_PAR_EN] ?
                         SER_PAR : SER_STOP;
            end
          end
        end
        SER_PAR: begin
          if (rx_bit_end) begin
            rx_cnt_q <= 6'h00;
            rx_par_q <= serial_in;
            rx_st_q <= SER_STOP;
          end
        end
        SER_STOP: begin
          // later stop bits just look like idle line
          if (rx_bit_end) begin
            rx_char <= rx_aligned;
            rx_char_valid <= 1'b1;
            rx_parity_err <= line_format_control_q[LFC_PAR_EN] &&
              (rx_par_q != uimc_parity(rx_aligned,
                 line_format_control_q[LFC_PAR_EVEN],
                 line_format_control_q[LFC_STICK]));
            rx_frame_err <= ~serial_in;
            rx_st_q <= SER_IDLE;
          end
        end
        default: rx_st_q <= SER_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_isid_rsvd_zero: assert property (isid_read |=> ~|wb_dat_o[5:4])
    else $error("identification bits 5:4 not zero");
  a_isid_fifo_ones: assert property (
    isid_read && fifo_enable |=> wb_dat_o[7:6] == 2'b11)
    else $error("identification bits 7:6 not set in fifo mode");
  a_isid_rls_top: assert property (
    isid_read && line_status_pend |=> wb_dat_o[3:0] == 4'h6)
    else $error("line status not reported first");
  a_isid_msr_last: assert property (
    isid_read && modem_status_pend && !line_status_pend && !rx_avail_pend &&
    !char_timeout_pend && !thre_pend_q |=> wb_dat_o[3:0] == 4'h0)
    else $error("modem status code wrong");
  a_thre_write_clr: assert property (
    thr_wr && !tx_load |=> !thre_pend_q)
    else $error("tx empty pending not cleared by write");
  a_thre_read_clr: assert property (
    isid_read && isid_code == ISID_THRE && !tx_load
    |=> !thre_pend_q && wb_dat_o[3:0] == 4'h2)
    else $error("tx empty pending not cleared by read");
  a_isid_pend_bit: assert property (
    isid_read && (line_status_pend || rx_avail_pend) |=> !wb_dat_o[0])
    else $error("pending bit not low with interrupt pending");
  a_isid_tmo_bit: assert property (
    isid_read && !fifo_enable |=> !wb_dat_o[3])
    else $error("timeout bit set outside fifo mode");
  a_term_rdy_pin: assert property (
    mlc_wr |=> terminal_ready_n == !$past(wb_dat_i[0]))
    else $error("terminal ready pin not inverted bit");
  a_req_send_pin: assert property (
    mlc_wr |=> request_send_n == !$past(wb_dat_i[1]))
    else $error("request to send pin not inverted bit");
  a_irq_gate_off: assert property (
    !modem_line_control_q[MLC_IRQ_GATE] |=> irq_oe_n)
    else $error("interrupt pin driven while gate bit clear");
  a_div_steer: assert property (
    rd && idx == IDX_DATA && divisor_select_bit
    |=> wb_dat_o[7:0] == $past(divisor[7:0]))
    else $error("divisor select did not reach divisor latch");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  c_thre_seen: cover property (isid_read && isid_code == ISID_THRE);
  c_rx_char: cover property (rx_char_valid && !rx_frame_err);
  c_irq_driven: cover property (irq_out && !irq_oe_n);
endmodule

// ===== verif/uimc_peer.sv
`timescale 1ns/1ps
// far-side serial peer: sends frames on serial_in and times serial_out
module uimc_peer (
  input wire logic clock,
  input wire logic baud_tick,
  input wire logic serial_out,
  output logic serial_in
);
  // idle line rests at mark, as a real peer's driver does
  initial serial_in = 1'b1;

  task automatic ticks(input int n);
    repeat (n) @(posedge clock iff baud_tick);
  endtask

  task automatic send(input logic [7:0] d, input int nb, input logic pe,
                      input logic pb, input logic s1, input logic s2);
    serial_in <= 1'b0;
    ticks(16);
    for (int i = 0; i < nb; i++) begin
      serial_in <= d[i];
      ticks(16);
    end
    if (pe) begin
      serial_in <= pb;
      ticks(16);
    end
    serial_in <= s1;
    ticks(16);
    // a spacing second stop may look like a new start to the far end
    serial_in <= s2;
    ticks(16);
    serial_in <= 1'b1;
  endtask

  // samples mid-bit, then counts ticks up to the next start edge
  task automatic grab(input int nb, input logic pe, output logic [8:0] b,
                      output int span);
    int t;
    b = 9'h000;
    @(posedge clock iff serial_out === 1'b0);
    ticks(8);
    t = 8;
    for (int i = 0; i < nb + pe; i++) begin
      ticks(16);
      b[i] = serial_out;
      t += 16;
    end
    for (int v = 1; v >= 0; v--) begin
      while (serial_out !== v[0] && t < 1000) begin
        @(posedge clock);
        t += baud_tick;
      end
    end
    span = t;
  endtask
endmodule

// ===== verif/uimc_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h exp %h", $time, (a), (b)); end end
module uimc_top_tb_top;
  import uimc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic tick = 1'b0;
  logic [1:0] bcnt = 2'h0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] pend = 4'h0;
  logic [31:0] rdat, r;
  logic ack, sout, sin, tr_n, rs_n, irq, oe_n, fe, rv, rpe, rfe;
  logic [15:0] div;
  logic [3:0] ien;
  logic [7:0] rch;
  int errors = 0;
  int tests_run = 0;
  int nv = 0;

  always #20 clock = ~clock;
  // baud strobe every fourth clock keeps frames short
  always @(posedge clock) begin
    bcnt <= bcnt + 2'h1;
    tick <= (bcnt == 2'h3);
  end

  // counts receive strobes so a lost or doubled pulse shows up
  always @(posedge clock) begin
    if (rv === 1'b1) nv <= nv + 1;
  end

  uimc_top dut_u (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .baud_tick(tick),
    .serial_in(sin), .serial_out(sout), .line_status_pend(pend[3]),
    .rx_avail_pend(pend[2]), .char_timeout_pend(pend[1]),
    .modem_status_pend(pend[0]), .terminal_ready_n(tr_n),
    .request_send_n(rs_n), .irq_out(irq), .irq_oe_n(oe_n),
    .fifo_enable(fe), .divisor(div), .int_enable(ien), .rx_char(rch),
    .rx_char_valid(rv), .rx_parity_err(rpe), .rx_frame_err(rfe));

  uimc_peer peer_u (.clock(clock), .baud_tick(tick), .serial_out(sout),
    .serial_in(sin));

  function automatic logic [7:0] msk(input logic [1:0] w);
    return 8'hFF >> (2'h3 - w);
  endfunction

  function automatic logic epar(input logic [7:0] m, input logic [7:0] l);
    return l[5] ? ~l[4] : (l[4] ? ^m : ~^m);
  endfunction

  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clock); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(r, {24'h0, e})
  endtask

  task automatic t_regs;
    rc(5'h08, 8'h01);
    rc(5'h0C, 8'h00);
    `CHK({tr_n, rs_n, oe_n, sout}, 4'hF)
    wr(5'h10, 8'hFF);
    rc(5'h10, 8'h1F);
    `CHK({tr_n, rs_n, oe_n}, 3'h0)
    wr(5'h10, 8'h04);
    rc(5'h10, 8'h04);
    `CHK({tr_n, rs_n, oe_n}, 3'h7)
    wr(5'h14, 8'hFF);
    rc(5'h14, 8'h00);
    wr(5'h0C, 8'h80);
    rc(5'h0D, 8'h00);
    wr(5'h00, 8'h34);
    wr(5'h04, 8'h12);
    `CHK(div, 16'h1234)
    rc(5'h00, 8'h34);
    wr(5'h0C, 8'h00);
    wr(5'h04, 8'h0F);
    `CHK({div, ien}, 20'h1234F)
    rc(5'h04, 8'h0F);
  endtask

  task automatic t_prio;
    logic [3:0] ps [5] = '{4'hF, 4'h7, 4'h3, 4'h1, 4'h0};
    logic [3:0] c;
    for (int f = 0; f < 2; f++) begin
      wr(5'h08, 8'(f));
      `CHK(fe, 1'(f))
      for (int k = 0; k < 5; k++) begin
        pend <= ps[k];
        c = ps[k][3] ? 4'h6 : ps[k][2] ? 4'h4 : (f && ps[k][1]) ? 4'hC :
            ps[k][0] ? 4'h0 : 4'h1;
        rc(5'h08, {{2{1'(f)}}, 2'b00, c});
        `CHK(irq, c != 4'h1)
      end
    end
    pend <= 4'h0;
  endtask

  task automatic t_break;
    wr(5'h0C, 8'h40);
    repeat (2) @(posedge clock);
    `CHK(sout, 1'b0)
    wr(5'h00, 8'h55);
    peer_u.ticks(40);
    `CHK(sout, 1'b0)
    wr(5'h0C, 8'h00);
    peer_u.ticks(200);
    `CHK(sout, 1'b1)
  endtask

  task automatic t_tx;
    logic [7:0] ls [7] = '{8'h00, 8'h04, 8'h05, 8'h1F, 8'h0A, 8'h2B, 8'h3B};
    logic [8:0] b;
    logic [7:0] m;
    int span, nb, ex;
    for (int i = 0; i < 7; i++) begin
      nb = 5 + ls[i][1:0];
      m = msk(ls[i][1:0]);
      ex = 16 * (1 + nb + ls[i][3]) + (!ls[i][2] ? 16 : (nb == 5 ? 24 : 32));
      wr(5'h0C, ls[i]);
      fork
        peer_u.grab(nb, ls[i][3], b, span);
        begin
          wr(5'h00, 8'hA7);
          wr(5'h00, 8'hA7);
        end
      join
      `CHK(b[7:0] & m, 8'hA7 & m)
      if (ls[i][3]) `CHK(b[nb], epar(8'hA7 & m, ls[i]))
      // start edges are seen on clocks, so allow one tick either way
      `CHK(span >= ex - 1 && span <= ex + 1, 1'b1)
      peer_u.ticks(240);
    end
  endtask

  task automatic t_thre;
    pend <= 4'h1;
    rc(5'h08, 8'hC2);
    rc(5'h08, 8'hC0);
    pend <= 4'h0;
    rc(5'h08, 8'hC1);
  endtask

  task automatic t_rx;
    logic [7:0] ls [7] = '{8'h1B, 8'h1B, 8'h07, 8'h03, 8'h2B, 8'h3B, 8'h00};
    logic [7:0] ds [7] = '{8'hA7, 8'hA7, 8'h5A, 8'h5A, 8'h3C, 8'h3C, 8'h15};
    logic [6:0] bad = 7'b0100010;
    logic [6:0] s1 = 7'b1110111;
    logic [6:0] s2 = 7'b1111011;
    logic [7:0] m;
    int n0;
    for (int i = 0; i < 7; i++) begin
      m = msk(ls[i][1:0]);
      wr(5'h0C, ls[i]);
      n0 = nv;
      peer_u.send(ds[i], 5 + ls[i][1:0], ls[i][3],
                  epar(ds[i] & m, ls[i]) ^ bad[i], s1[i], s2[i]);
      `CHK(rch, ds[i] & m)
      `CHK(rpe, bad[i])
      `CHK(rfe, ~s1[i])
      `CHK(nv, n0 + 1)
      rc(5'h00, ds[i] & m);
      peer_u.ticks(160);
    end
  endtask

  task automatic conclude;
    $display("Comparisons %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_prio;
    t_break;
    t_tx;
    t_thre;
    t_rx;
    conclude;
  end

  // the whole sequence needs about 22000 clocks; this leaves ample slack
  initial begin
    repeat (80000) @(posedge clock);
    errors++;
    conclude;
  end
endmodule
